// File: core/otl_overtemp_line.sv
// Behaviour
// R1: Eight-bit accumulated assertion time limit register
// R2: Timer above limit sets flag, raises alert
// R3: Mask bit blocks alert, flag still sets
// R4: Limit zero alerts on first assertion
// R5: Limit one alerts after 45.52 ms
// R6: Timer monitoring off after reset, enable bit
// R7: Pin works only with function and enable
// R8: Pin function field decodes four functions
// R9: Three drive enables for three channels
// R10: No enables means input-only line
// R11: External low assertions timed like own
// R12: Override forces running fans to full
// R13: Drive low above critical limit
// R14: Hold while above, release at limit
// R15: Drive lasts at least one monitoring cycle
// R16: Three critical limits at consecutive addresses
// R17: Lowest limit codes disable the channel
// R18: Enable bit cleared disables line, timer and drive; sticky flag, alert and other pin functions stay
// R19: Low selectable or single high frequency
// R20: Timer accumulates, saturates, clears on read
// R21: Bit0 first, then 22.76 ms steps
// R22: Flag sticky; alert follows unmasked flags
`timescale 1ns/100ps
module otl_overtemp_line
    import otl_pkg::*;
#(
    parameter int TIMER_TICKS = OTL_TIMER_TICKS,   // Cycles per timer step
    parameter int PWM_LOW_DIV = OTL_PWM_LOW_DIV     // Base divide of low PWM rates
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Monitoring results
    input  wire otl_temps_s temps_i,
    input  wire logic       meas_done_i,
    input  wire logic       offset64_mode_i,
    // Fans
    input  wire logic [2:0] fan_running_i,
    output logic      [2:0] full_speed_override_o,
    input  wire logic       pwm_high_freq_i,
    input  wire logic [2:0] pwm_low_sel_i,
    output logic            pwm_tick_o,
    // Shared pin, open drain
    input  wire logic       shared_pin_i,
    output logic            shared_pin_o,
    output logic            shared_pin_oe_o,
    output logic            fourth_tach_input_o,
    // Status
    output logic            overtemp_line_o,
    output logic            smbalert_o
);

    localparam int SUB_W = $clog2(TIMER_TICKS + 1);
    localparam int PWM_W = $clog2(PWM_LOW_DIV * 128 + 1);

    // Refuse settings the counters cannot serve
    if (TIMER_TICKS < 2 || PWM_LOW_DIV < 1) begin : g_bad_param
        $error("otl_overtemp_line: TIMER_TICKS must be >= 2, PWM_LOW_DIV >= 1");
    end

    // Whole state of the block
    typedef struct packed {
        otl_regs_s        regs;        // Software registers
        logic [7:0]       timer;       // Accumulated assertion time
        logic             half;        // First step after bit 0 passed
        logic [SUB_W-1:0] sub;         // Cycles inside one step
        logic             flag;        // Sticky timer limit flag
        logic [2:0]       drive;       // Per-channel drive latches
        logic [7:0]       rdata;       // Read data
        logic [PWM_W-1:0] pwm_cnt;     // PWM rate divider
        logic             pwm_tick;    // One-cycle PWM rate enable
    } otl_state_s;

    otl_state_s s_q;
    otl_state_s s_d;

    logic       line_fn;       // Pin owned by the overtemperature function
    logic       line_active;   // Line seen low
    logic       drive_any;     // Device pulls line low
    logic       timer_rd;      // Timer read this cycle
    logic [7:0] timer_next;    // Timer after read and step
    logic [PWM_W-1:0] pwm_div; // Current PWM divide

    // Pin ownership and line level
    always_comb begin
        line_fn     = s_q.regs.cfg3[OTL_CFG3_ENABLE_BIT]                  // R7 R18 R6
                    && (s_q.regs.cfg4[1:0] == OTL_PIN_LINE);              // R8
        drive_any   = line_fn && (|s_q.drive);                            // R10
        // External pull counts the same as our own drive
        line_active = line_fn && (!shared_pin_i || drive_any);            // R11
        timer_rd    = reg_rd_i && (reg_addr_i == OTL_REG_TIMER);
    end

    // Critical limit comparison, result used once per monitoring cycle
    function automatic logic over_limit(input logic [9:0] t, input logic [7:0] lim,
                                        input logic offs);
        logic [9:0] t_u;
        logic [9:0] l_u;
        t_u = offs ? t : (t ^ 10'h200);
        l_u = offs ? {lim, 2'h0} : {lim ^ 8'h80, 2'h0};
        // Quarter-degree resolution: above limit means at least limit + 0.25
        over_limit = t_u > l_u;                                           // R13 R14
    endfunction : over_limit

    function automatic logic limit_live(input logic [7:0] lim, input logic offs);
        // Lowest codes switch the channel off in either format
        limit_live = offs ? (lim > OTL_OFFS_DISABLE)
                          : ($signed(lim) > $signed(OTL_TWOS_DISABLE));   // R17
    endfunction : limit_live

    // Next-state logic
    always_comb begin
        logic [9:0] t_ch [3];
        logic       en_ch;
        logic       step;
        s_d      = s_q;
        t_ch[0]  = temps_i.remote_one;
        t_ch[1]  = temps_i.local_t;
        t_ch[2]  = temps_i.remote_two;
        en_ch    = 1'b0;
        step     = 1'b0;

        // Register writes; critical limits sit at three consecutive offsets
        if (reg_wr_i) begin
            case (reg_addr_i)
                OTL_REG_CRIT_R1:    s_d.regs.crit[0] = reg_wdata_i;       // R16
                OTL_REG_CRIT_LOCAL: s_d.regs.crit[1] = reg_wdata_i;       // R16
                OTL_REG_CRIT_R2:    s_d.regs.crit[2] = reg_wdata_i;       // R16
                OTL_REG_MASK2:      s_d.regs.mask2   = reg_wdata_i;
                OTL_REG_CFG3:       s_d.regs.cfg3    = reg_wdata_i;
                OTL_REG_TLIMIT:     s_d.regs.tlimit  = reg_wdata_i;       // R1
                OTL_REG_CFG5:       s_d.regs.cfg5    = reg_wdata_i;
                OTL_REG_CFG4:       s_d.regs.cfg4    = reg_wdata_i;
                // Write one to clear the sticky flag
                OTL_REG_STATUS2: begin
                    if (reg_wdata_i[OTL_FLAG_BIT]) begin
                        s_d.flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Register reads, data shows one cycle later
        if (reg_rd_i) begin
            case (reg_addr_i)
                OTL_REG_CRIT_R1:    s_d.rdata = s_q.regs.crit[0];
                OTL_REG_CRIT_LOCAL: s_d.rdata = s_q.regs.crit[1];
                OTL_REG_CRIT_R2:    s_d.rdata = s_q.regs.crit[2];
                OTL_REG_MASK2:      s_d.rdata = s_q.regs.mask2;
                OTL_REG_CFG3:       s_d.rdata = s_q.regs.cfg3;
                OTL_REG_TIMER:      s_d.rdata = s_q.timer;
                OTL_REG_TLIMIT:     s_d.rdata = s_q.regs.tlimit;
                OTL_REG_CFG5:       s_d.rdata = s_q.regs.cfg5;
                OTL_REG_CFG4:       s_d.rdata = s_q.regs.cfg4;
                OTL_REG_STATUS2:    s_d.rdata = {2'h0, s_q.flag, 5'h00};
                default:            s_d.rdata = 8'h00;
            endcase
        end

        // Assertion timer; a read restarts it from zero
        timer_next = s_q.timer;
        if (timer_rd) begin
            timer_next = 8'h00;                                           // R20
            s_d.half   = 1'b0;
            s_d.sub    = '0;
        end
        if (line_active) begin
            if (timer_next == 8'h00) begin
                // First assertion, or read during assertion, marks bit 0
                timer_next = 8'h01;                                       // R21 R20
            end
            if (!timer_rd) begin
                if (s_q.sub == SUB_W'(TIMER_TICKS - 1)) begin
                    s_d.sub = '0;
                    step    = 1'b1;
                end else begin
                    s_d.sub = s_q.sub + 1'b1;
                end
            end
        end
        if (step) begin
            if (timer_next == 8'h01 && !s_q.half) begin
                // Bit 1 only rises after two steps of assertion
                s_d.half = 1'b1;                                          // R21 R5
            end else if (timer_next != 8'hFF) begin
                // Stop at full scale until cleared
                timer_next = timer_next + 8'h01;                          // R20
            end
        end
        s_d.timer = timer_next;

        // Limit compare; the set wins over a same-cycle clear
        if (timer_next > s_q.regs.tlimit) begin
            s_d.flag = 1'b1;                                              // R2 R4 R5 R22
        end

        // Channel drive decisions once per monitoring cycle
        if (!line_fn) begin
            s_d.drive = 3'h0;                                             // R18
        end else if (meas_done_i) begin
            for (int c = 0; c < 3; c++) begin
                en_ch = s_q.regs.cfg5[OTL_CFG5_DRIVE_LSB + c]             // R9
                        && limit_live(s_q.regs.crit[c], offset64_mode_i);
                // Latch holds until the next result, so at least one cycle
                s_d.drive[c] = en_ch
                        && over_limit(t_ch[c], s_q.regs.crit[c], offset64_mode_i); // R13 R14 R15
            end
        end

        // Fan PWM rate: one high rate or a choice of low ones
        if (s_q.pwm_cnt >= pwm_div - 1'b1) begin
            s_d.pwm_cnt  = '0;
            s_d.pwm_tick = 1'b1;                                          // R19
        end else begin
            s_d.pwm_cnt  = s_q.pwm_cnt + 1'b1;
            s_d.pwm_tick = 1'b0;
        end
    end

    // PWM divide select
    always_comb begin
        pwm_div = pwm_high_freq_i ? PWM_W'(OTL_PWM_HIGH_DIV)
                                  : PWM_W'(PWM_LOW_DIV << pwm_low_sel_i);  // R19
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.regs.crit   <= {3{OTL_RST_CRIT}};
            s_q.regs.mask2  <= OTL_RST_CFG;
            s_q.regs.cfg3   <= OTL_RST_CFG;                               // R6
            s_q.regs.tlimit <= OTL_RST_TLIMIT;
            s_q.regs.cfg5   <= OTL_RST_CFG;
            s_q.regs.cfg4   <= OTL_RST_CFG;
            s_q.timer       <= 8'h00;
            s_q.half        <= 1'b0;
            s_q.sub         <= '0;
            s_q.flag        <= 1'b0;
            s_q.drive       <= 3'h0;
            s_q.rdata       <= 8'h00;
            s_q.pwm_cnt     <= '0;
            s_q.pwm_tick    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    always_comb begin
        reg_rdata_o     = s_q.rdata;
        pwm_tick_o      = s_q.pwm_tick;
        overtemp_line_o = line_active;
        // Alert stays up while the unmasked flag stands
        smbalert_o      = s_q.flag && !s_q.regs.mask2[OTL_FLAG_BIT];      // R3 R22
        // Stopped fans are left alone; only running ones are boosted
        full_speed_override_o = (line_active && s_q.regs.cfg3[OTL_CFG3_OVERRIDE_BIT])
                                ? fan_running_i : 3'h0;                   // R12
        shared_pin_o    = 1'b0;
        // Open drain: enable only to pull low
        case (s_q.regs.cfg4[1:0])
            OTL_PIN_LINE:  shared_pin_oe_o = drive_any;                   // R9 R10
            OTL_PIN_ALERT: shared_pin_oe_o = smbalert_o;                  // R8
            default:       shared_pin_oe_o = 1'b0;
        endcase
        fourth_tach_input_o = (s_q.regs.cfg4[1:0] == OTL_PIN_TACH) ? shared_pin_i : 1'b1; // R8
    end

endmodule : otl_overtemp_line

// File: core/otl_pkg.sv
package otl_pkg;

    // Register byte offsets on the device register port
    localparam logic [7:0] OTL_REG_CRIT_R1    = 8'h6A;
    localparam logic [7:0] OTL_REG_CRIT_LOCAL = 8'h6B;
    localparam logic [7:0] OTL_REG_CRIT_R2    = 8'h6C;
    localparam logic [7:0] OTL_REG_MASK2      = 8'h75;
    localparam logic [7:0] OTL_REG_CFG3       = 8'h78;
    localparam logic [7:0] OTL_REG_TIMER      = 8'h79;
    localparam logic [7:0] OTL_REG_TLIMIT     = 8'h7A;
    localparam logic [7:0] OTL_REG_CFG5       = 8'h7C;
    localparam logic [7:0] OTL_REG_CFG4       = 8'h7D;
    localparam logic [7:0] OTL_REG_STATUS2    = 8'h90;

    // Field positions
    localparam int OTL_CFG3_ENABLE_BIT   = 1;
    localparam int OTL_CFG3_OVERRIDE_BIT = 2;
    localparam int OTL_FLAG_BIT          = 5;
    localparam int OTL_CFG5_DRIVE_LSB    = 5;

    // Shared pin function codes
    localparam logic [1:0] OTL_PIN_TACH  = 2'h0;
    localparam logic [1:0] OTL_PIN_LINE  = 2'h1;
    localparam logic [1:0] OTL_PIN_ALERT = 2'h2;
    localparam logic [1:0] OTL_PIN_GPIO  = 2'h3;

    // Values after reset
    localparam logic [7:0] OTL_RST_CRIT   = 8'h64;
    localparam logic [7:0] OTL_RST_TLIMIT = 8'h00;
    localparam logic [7:0] OTL_RST_CFG    = 8'h00;

    // Disabled-limit thresholds per temperature format
    localparam logic [7:0] OTL_OFFS_DISABLE = 8'h00;
    localparam logic [7:0] OTL_TWOS_DISABLE = 8'h80;

    // Timing
    localparam int OTL_CLK_PERIOD_NS  = 40;
    localparam int OTL_TIMER_RES_US   = 22760;
    localparam int OTL_TIMER_TICKS    = OTL_TIMER_RES_US * 1000 / OTL_CLK_PERIOD_NS;
    localparam int OTL_PWM_HIGH_DIV   = 1;
    localparam int OTL_PWM_LOW_DIV    = 256;

    // Temperatures of one monitoring cycle, degrees with two fraction bits
    typedef struct packed {
        logic [9:0] remote_two;
        logic [9:0] local_t;
        logic [9:0] remote_one;
    } otl_temps_s;

    // Software-visible registers
    typedef struct packed {
        logic [2:0][7:0] crit;
        logic [7:0]      mask2;
        logic [7:0]      cfg3;
        logic [7:0]      tlimit;
        logic [7:0]      cfg5;
        logic [7:0]      cfg4;
    } otl_regs_s;

endpackage : otl_pkg

// File: tb/otl_hot_model.sv
`timescale 1ns/100ps
// Far-side hot source on the open-drain line, which has a pull-up
module otl_hot_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [7:0] hold_i,
    input  wire logic       oe_i,
    output logic            pin_o
);
    logic [7:0] cnt_q; // Cycles left to hold the line low
    // Pull low only for the commanded span
    always_ff @(posedge clk_i) begin
        if (rst_i || go_i) begin
            cnt_q <= rst_i ? 8'h00 : hold_i;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // Released line returns to the pull-up level
    assign pin_o = !(oe_i || cnt_q != 8'h00);
endmodule : otl_hot_model

// File: tb/otl_overtemp_line_sva.sv
`timescale 1ns/100ps
module otl_overtemp_line_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       meas_done_i,
    input wire logic [2:0] fan_running_i,
    input wire logic [2:0] full_speed_override_o,
    input wire logic       pwm_high_freq_i,
    input wire logic       pwm_tick_o,
    input wire logic       shared_pin_i,
    input wire logic       shared_pin_o,
    input wire logic       shared_pin_oe_o,
    input wire logic       fourth_tach_input_o,
    input wire logic       overtemp_line_o,
    input wire logic       smbalert_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ovr_fans; (full_speed_override_o & ~fan_running_i) == 3'h0; endproperty
    a_ovr_fans: assert property (p_ovr_fans) else $error("override on a stopped fan");
    property p_ovr_line; |full_speed_override_o |-> overtemp_line_o; endproperty
    a_ovr_line: assert property (p_ovr_line) else $error("override without line");
    property p_ext; overtemp_line_o && !shared_pin_oe_o |-> !shared_pin_i; endproperty
    a_ext: assert property (p_ext) else $error("line active with pin high");
    property p_own; shared_pin_oe_o && !smbalert_o |-> overtemp_line_o && !shared_pin_o; endproperty
    a_own: assert property (p_own) else $error("own drive not seen as line");
    // Drive may only drop after a new measurement or a register change
    property p_hold; $fell(shared_pin_oe_o) |-> $past(meas_done_i) || $past(reg_wr_i); endproperty
    a_hold: assert property (p_hold) else $error("drive dropped early");
    property p_alert;
        $rose(smbalert_o) |-> $past(overtemp_line_o) || $past(reg_wr_i) || $past(reg_wr_i, 2);
    endproperty
    a_alert: assert property (p_alert) else $error("alert without cause");
    property p_rd_hold; !$past(reg_rd_i) |-> $stable(reg_rdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_tach; !fourth_tach_input_o |-> !shared_pin_i; endproperty
    a_tach: assert property (p_tach) else $error("tach low with pin high");
    property p_fast; pwm_high_freq_i [*3] |-> pwm_tick_o; endproperty
    a_fast: assert property (p_fast) else $error("high rate tick missing");
    property p_slow; !pwm_high_freq_i [*3] ##0 pwm_tick_o |=> !pwm_tick_o; endproperty
    a_slow: assert property (p_slow) else $error("low rate ticks adjacent");
    c_alert: cover property ($rose(smbalert_o));
    c_drive: cover property ($rose(shared_pin_oe_o));
    c_ovr: cover property (|full_speed_override_o);
endmodule : otl_overtemp_line_sva
bind otl_overtemp_line otl_overtemp_line_sva sva_u (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .meas_done_i, .fan_running_i, .full_speed_override_o, .pwm_high_freq_i, .pwm_tick_o, .shared_pin_i,
    .shared_pin_o, .shared_pin_oe_o, .fourth_tach_input_o, .overtemp_line_o, .smbalert_o);

// File: tb/otl_overtemp_line_test.sv
`timescale 1ns/100ps
module otl_overtemp_line_test;
    import otl_pkg::*;
    logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, meas_done_i = 0, offset64_mode_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, hold = 8'h00;
    logic [2:0] fan_running_i = 3'h5, pwm_low_sel_i = 3'h1, full_speed_override_o;
    logic pwm_high_freq_i = 1, go = 0, pwm_tick_o, shared_pin_i, shared_pin_o, shared_pin_oe_o;
    logic fourth_tach_input_o, overtemp_line_o, smbalert_o;
    otl_temps_s temps_i = '0;
    int n_errors = 0, cmp_count = 0;
    // Short timer step and PWM divide keep the run brief
    otl_overtemp_line #(.TIMER_TICKS(4), .PWM_LOW_DIV(2)) dut_u (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .temps_i, .meas_done_i, .offset64_mode_i, .fan_running_i,
        .full_speed_override_o, .pwm_high_freq_i, .pwm_low_sel_i, .pwm_tick_o, .shared_pin_i,
        .shared_pin_o, .shared_pin_oe_o, .fourth_tach_input_o, .overtemp_line_o, .smbalert_o);
    otl_hot_model hot_u (.clk_i, .rst_i, .go_i(go), .hold_i(hold), .oe_i(shared_pin_oe_o), .pin_o(shared_pin_i));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i); reg_addr_i <= a; reg_wdata_i <= v; reg_wr_i <= 1;
        @(posedge clk_i); reg_wr_i <= 0;
        #1;
    endtask : wr
    // Read data lands at the edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i); reg_addr_i <= a; reg_rd_i <= 1;
        @(posedge clk_i); reg_rd_i <= 0;
        #1 chk(reg_rdata_o, e);
    endtask : rd
    // Far side holds the line low for n cycles
    task automatic pull(input logic [7:0] n);
        @(posedge clk_i); hold <= n; go <= 1;
        @(posedge clk_i); go <= 0;
        repeat (n + 2) @(posedge clk_i);
        #1;
    endtask : pull
    task automatic meas(input int c, input logic [9:0] v);
        @(posedge clk_i); temps_i <= 30'(v) << (10 * c); meas_done_i <= 1;
        @(posedge clk_i); meas_done_i <= 0;
        #1;
    endtask : meas
    task automatic t_reset;
        int n;
        n = 0;
        // High rate: a tick on every cycle
        repeat (8) begin
            @(posedge clk_i);
            #1 n += int'(pwm_tick_o);
        end
        chk(8'(n), 8'h08);
        chk(shared_pin_o, 8'h00);
        for (int c = 0; c < 3; c++) rd(OTL_REG_CRIT_R1 + 8'(c), 8'h64);
        rd(OTL_REG_TLIMIT, 8'h00);
        rd(8'h10, 8'h00);
        wr(OTL_REG_TLIMIT, 8'hA5);
        rd(OTL_REG_TLIMIT, 8'hA5);
        wr(OTL_REG_TLIMIT, 8'h00);
    endtask : t_reset
    task automatic t_off;
        pull(6);
        rd(OTL_REG_TIMER, 8'h00);
        wr(OTL_REG_CFG4, 8'h01);
        pull(6);
        rd(OTL_REG_TIMER, 8'h00);
    endtask : t_off
    task automatic t_timer;
        wr(OTL_REG_CFG3, 8'h02);
        pull(2);
        chk(smbalert_o, 1);
        rd(OTL_REG_STATUS2, 8'h20);
        rd(OTL_REG_TIMER, 8'h01);
        rd(OTL_REG_TIMER, 8'h00);
        wr(OTL_REG_STATUS2, 8'h20);
        chk(smbalert_o, 0);
        wr(OTL_REG_TLIMIT, 8'h01);
        pull(6);
        chk(smbalert_o, 0);
        pull(4);
        chk(smbalert_o, 1);
        rd(OTL_REG_TIMER, 8'h02);
        wr(OTL_REG_STATUS2, 8'h20);
        wr(OTL_REG_TLIMIT, 8'h00);
        wr(OTL_REG_MASK2, 8'h20);
        pull(2);
        chk(smbalert_o, 0);
        rd(OTL_REG_STATUS2, 8'h20);
        wr(OTL_REG_MASK2, 8'h00);
        chk(smbalert_o, 1);
        wr(OTL_REG_STATUS2, 8'h20);
    endtask : t_timer
    task automatic t_drive;
        int n;
        n = 0;
        @(posedge clk_i);
        pwm_high_freq_i <= 0;
        wr(OTL_REG_CFG3, 8'h06);
        // Low rate, select 1 on a base divide of 2: one tick in four cycles
        repeat (8) begin
            @(posedge clk_i);
            #1 n += int'(pwm_tick_o);
        end
        chk(8'(n), 8'h02);
        for (int c = 0; c < 3; c++) begin
            wr(OTL_REG_CFG5, 8'h20 << c);
            meas(c, 10'h191);
            chk(shared_pin_oe_o, 1);
            chk(overtemp_line_o, 1);
            chk(full_speed_override_o, 3'h5);
            meas(c, 10'h190);
            chk(shared_pin_oe_o, 0);
        end
        wr(OTL_REG_CFG5, 8'h00);
        meas(0, 10'h191);
        chk(shared_pin_oe_o, 0);
        wr(OTL_REG_CFG5, 8'h20);
        wr(OTL_REG_CRIT_R1, 8'h80);
        meas(0, 10'h000);
        chk(shared_pin_oe_o, 0);
        wr(OTL_REG_CRIT_R1, 8'h64);
        meas(0, 10'h191);
        wr(OTL_REG_CFG3, 8'h00);
        chk(shared_pin_oe_o, 0);
        wr(OTL_REG_STATUS2, 8'h20);
    endtask : t_drive
    task automatic t_pin;
        wr(OTL_REG_CFG4, 8'h00);
        @(posedge clk_i); hold <= 8'h04; go <= 1;
        @(posedge clk_i); go <= 0;
        #1 chk(fourth_tach_input_o, 0);
        repeat (5) @(posedge clk_i);
        #1 chk(fourth_tach_input_o, 1);
        wr(OTL_REG_CFG3, 8'h02);
        wr(OTL_REG_CFG4, 8'h01);
        pull(2);
        wr(OTL_REG_CFG4, 8'h02);
        chk(shared_pin_oe_o, 1);
        wr(OTL_REG_CFG4, 8'h03);
        chk(shared_pin_oe_o, 0);
        chk(overtemp_line_o, 0);
    endtask : t_pin
    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Hang guard, far beyond the expected run
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_off();
        t_timer();
        t_drive();
        t_pin();
        close_out();
    end
endmodule : otl_overtemp_line_test
